/* File: hw/fspr_defines.vh */
// What this block does
// - protect_sel_lo lives at status_one bit 7, non-volatile, selects write protection.
// - block_protect_field lives at status_one bits 6:2, non-volatile, sizes protected region.
// - block_protect_field changes only by write status command, never when hardware protected.
// - Page program, page erase, block erase into protected region are rejected.
// - Chip erase runs only if low protect bits zero with invert clear, or ones with invert set.
// - write_latch_flag read-only at status_one bit 1; when clear, writes are refused.
// - busy_flag at status_one bit 0 is set during program, erase or status write.
// - suspended_flag at status_two bit 7 sets after suspend command 75h.
// - suspended_flag clears on resume 7Ah, software reset pair, or power cycle.
// - protect_invert at status_two bit 6, non-volatile read/write, picks protected region.
// - secure_lock_bits at status_two bits 5:3, one-time programmable, reset to zero.
// - each secure_lock_bits bit may be set alone by register write, never cleared.
// - a security register becomes read-only once its lock bit is set.
// - four_lane_enable at status_two bit 1 turns guard and pause pins into data lanes.
// - protect_sel_hi at status_two bit 0, non-volatile read/write, selects write protection.
// - Protect select 00 free, 01 locked when guard pin low, 10 until power cycle, 11 forever.
// - A program or erase covering any protected part is ignored, contents untouched.
// - Four-lane read commands are accepted only while four_lane_enable is set.
`ifndef FSPR_DEFINES_VH
`define FSPR_DEFINES_VH
// ==========================================================================
// Field positions
`define FSPR_S1_SEL_LO 7
`define FSPR_S1_BP_HI 6
`define FSPR_S1_BP_LO 2
`define FSPR_S1_LATCH 1
`define FSPR_S1_BUSY 0
`define FSPR_S2_SUSP 7
`define FSPR_S2_INV 6
`define FSPR_S2_LOCK_HI 5
`define FSPR_S2_LOCK_LO 3
`define FSPR_S2_RSVD 2
`define FSPR_S2_QUAD 1
`define FSPR_S2_SEL_HI 0
// ==========================================================================
// Reset values and protect-select codes
`define FSPR_RST_NV 8'h00
`define FSPR_SEL_SOFT 2'h0
`define FSPR_SEL_HW 2'h1
`define FSPR_SEL_PWR 2'h2
`define FSPR_SEL_OTP 2'h3
// ==========================================================================
// Operation codes
`define FSPR_OP_NONE 4'h0
`define FSPR_OP_WRSR 4'h1
`define FSPR_OP_PROG 4'h2
`define FSPR_OP_PERASE 4'h3
`define FSPR_OP_BERASE 4'h4
`define FSPR_OP_CERASE 4'h5
`define FSPR_OP_SUSP 4'h6
`define FSPR_OP_RESUME 4'h7
`define FSPR_OP_WREN 4'h8
`define FSPR_OP_WRDI 4'h9
`define FSPR_OP_QREAD 4'ha
`define FSPR_OP_SRST 4'hb
`define FSPR_OP_SECW 4'hc
`endif

/* File: hw/fspr_regs.v */
`include "fspr_defines.vh"

module fspr_regs #(
  parameter AW = 19, // Byte address width of the array.
  parameter BUSY_CYCLES = 16 // Length of an internal write in clocks.
) (
  input wire clock, // System clock.
  input wire rstn, // Synchronous reset, active low.
  input wire clk_en, // Freezes all state while low.
  input wire power_up_n, // Low marks a power cycle, from another domain.
  input wire guard_pin_n, // Write-guard pin, low locks when selected, async.
  input wire cmd_valid, // Decoded command strobe.
  input wire [3:0] cmd_op, // Decoded operation.
  input wire [AW-1:0] cmd_addr, // Target address of program or erase.
  input wire [AW-1:0] cmd_len, // Bytes covered minus one.
  input wire [7:0] cmd_s1, // Data for status_one.
  input wire [7:0] cmd_s2, // Data for status_two.
  input wire [1:0] cmd_sec_idx, // Security register targeted, 0 to 2.
  output reg [7:0] status_one, // First status register image.
  output reg [7:0] status_two, // Second status register image.
  output reg cmd_accept, // One-cycle pulse, command carried out.
  output reg cmd_reject, // One-cycle pulse, command refused.
  output reg lanes_quad // Guard and pause pins act as data lanes.
);
  // ========================================================================
  // State
  reg sel_lo_reg, sel_hi_reg, inv_reg, quad_reg, latch_reg, susp_reg;
  reg [4:0] bp_reg;
  reg [2:0] lock_reg;
  reg [15:0] busy_reg;
  reg g1_reg, g2_reg, p1_reg, p2_reg;
  reg pwr_lock_reg;
  wire busy = (busy_reg != 16'h0000);

  // Returns 1 when [lo, hi] overlaps the region marked protected.
  function prot_hit;
    input [4:0] bp;
    input inv;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    reg [AW:0] size;
    reg top;
    reg [AW:0] plo, phi;
    begin
      size = {(AW+1){1'b0}};
      top = ~bp[3];
      if (bp[2:0] == 3'h0) size = {(AW+1){1'b0}};
      else if (bp[4] == 1'b0) begin
        if (bp[2]) size = {1'b1, {AW{1'b0}}};
        else size = ({1'b1, {AW{1'b0}}} >> (4 - bp[1:0]));
      end else begin
        if (bp[2:0] == 3'h7) size = {1'b1, {AW{1'b0}}};
        else if (bp[2]) size = ({1'b1, {AW{1'b0}}} >> 4);
        else size = ({1'b1, {AW{1'b0}}} >> (8 - bp[1:0]));
      end
      if (inv) begin
        size = {1'b1, {AW{1'b0}}} - size;
        top = ~top;
      end
      if (size == {(AW+1){1'b0}}) prot_hit = 1'b0;
      else begin
        if (top) begin
          plo = {1'b1, {AW{1'b0}}} - size;
          phi = {1'b0, {AW{1'b1}}};
        end else begin
          plo = {(AW+1){1'b0}};
          phi = size - 1'b1;
        end
        prot_hit = ({1'b0, hi} >= plo) && ({1'b0, lo} <= phi);
      end
    end
  endfunction

  // ========================================================================
  // Pin synchronisers; first stage feeds only the second.
  always @(posedge clock) begin
    if (!rstn) begin
      g1_reg <= 1'b1;
      g2_reg <= 1'b1;
      p1_reg <= 1'b1;
      p2_reg <= 1'b1;
    end else if (clk_en) begin
      g1_reg <= guard_pin_n;
      g2_reg <= g1_reg;
      p1_reg <= power_up_n;
      p2_reg <= p1_reg;
    end
  end

  // ========================================================================
  // Command decode; refusals come first so nothing partial is ever applied.
  wire [1:0] sel = {sel_hi_reg, sel_lo_reg};
  // Guard pin acts only while it has its control role.
  wire sr_locked = (sel == `FSPR_SEL_OTP) || (sel == `FSPR_SEL_PWR) ||
                   ((sel == `FSPR_SEL_HW) && !g2_reg && !quad_reg);
  wire [AW-1:0] last = cmd_addr + cmd_len;
  wire hit = prot_hit(bp_reg, inv_reg, cmd_addr, last);
  wire chip_ok = (bp_reg[2:0] == 3'h0 && !inv_reg) || (bp_reg[2:0] == 3'h7 && inv_reg);
  reg ok;
  always @* begin
    ok = 1'b0;
    case (cmd_op)
      `FSPR_OP_WRSR: ok = latch_reg && !busy && !sr_locked;
      `FSPR_OP_PROG, `FSPR_OP_PERASE, `FSPR_OP_BERASE: ok = latch_reg && !busy && !hit;
      `FSPR_OP_CERASE: ok = latch_reg && !busy && chip_ok;
      `FSPR_OP_SECW: ok = latch_reg && !busy && !lock_reg[cmd_sec_idx];
      `FSPR_OP_QREAD: ok = quad_reg && !busy;
      `FSPR_OP_SUSP: ok = busy;
      `FSPR_OP_RESUME: ok = susp_reg;
      default: ok = 1'b1;
    endcase
  end

  // ========================================================================
  // Register update. Non-volatile fields survive rstn; a software reset only
  // clears volatile state, and the power-cycle lock clears on power_up_n low.
  always @(posedge clock) begin
    if (!rstn) begin
      latch_reg <= 1'b0;
      susp_reg <= 1'b0;
      busy_reg <= 16'h0000;
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
      status_one <= `FSPR_RST_NV;
      status_two <= `FSPR_RST_NV;
      lanes_quad <= 1'b0;
    end else if (clk_en) begin
      cmd_accept <= cmd_valid && ok;
      cmd_reject <= cmd_valid && !ok;
      if (busy && !susp_reg) busy_reg <= busy_reg - 16'h0001;
      if (cmd_valid && ok) begin
        case (cmd_op)
          `FSPR_OP_WREN: latch_reg <= 1'b1;
          `FSPR_OP_WRDI: latch_reg <= 1'b0;
          `FSPR_OP_SUSP: susp_reg <= 1'b1;
          `FSPR_OP_RESUME: susp_reg <= 1'b0;
          `FSPR_OP_SRST: begin
            susp_reg <= 1'b0;
            busy_reg <= 16'h0000;
            latch_reg <= 1'b0;
          end
          `FSPR_OP_QREAD: latch_reg <= latch_reg;
          `FSPR_OP_NONE: latch_reg <= latch_reg;
          default: begin
            latch_reg <= 1'b0;
            busy_reg <= BUSY_CYCLES[15:0];
          end
        endcase
      end
      if (!p2_reg) susp_reg <= 1'b0;
      status_one <= {sel_lo_reg, bp_reg, latch_reg, busy};
      status_two <= {susp_reg, inv_reg, lock_reg, 1'b0, quad_reg, sel_hi_reg};
      lanes_quad <= quad_reg;
    end
  end

  // Non-volatile fields: changed only by their own write, except protect select, cleared by a power cycle while power-locked; model of the cell array.
  always @(posedge clock) begin
    if (!rstn) begin
      pwr_lock_reg <= 1'b0;
    end else if (clk_en) begin
      pwr_lock_reg <= 1'b0;
    end
  end
  always @(posedge clock) begin
    if (clk_en && !p2_reg && sel == `FSPR_SEL_PWR) begin
      sel_hi_reg <= 1'b0;
      sel_lo_reg <= 1'b0;
    end else if (clk_en && rstn && cmd_valid && ok && cmd_op == `FSPR_OP_WRSR) begin
      sel_lo_reg <= cmd_s1[`FSPR_S1_SEL_LO];
      bp_reg <= cmd_s1[`FSPR_S1_BP_HI:`FSPR_S1_BP_LO];
      inv_reg <= cmd_s2[`FSPR_S2_INV];
      lock_reg <= lock_reg | cmd_s2[`FSPR_S2_LOCK_HI:`FSPR_S2_LOCK_LO];
      quad_reg <= cmd_s2[`FSPR_S2_QUAD];
      sel_hi_reg <= cmd_s2[`FSPR_S2_SEL_HI];
    end
  end
  // Power-up defaults for the cells; simulation starts from the erased state.
  initial begin
    sel_lo_reg = 1'b0;
    sel_hi_reg = 1'b0;
    bp_reg = 5'h00;
    inv_reg = 1'b0;
    quad_reg = 1'b0;
    lock_reg = 3'h0;
  end
endmodule // fspr_regs

/* File: dv/fspr_regs_monitor.sv */
`include "fspr_defines.vh"
// ==========================================================================
// Checker on the register bank ports
module fspr_regs_monitor #(
  parameter BUSY_CYCLES = 16
) (
  input wire clock, // System clock.
  input wire rstn, // Synchronous reset, active low.
  input wire cmd_valid, // Command strobe.
  input wire [3:0] cmd_op, // Decoded operation.
  input wire [7:0] status_one, // First status image.
  input wire [7:0] status_two, // Second status image.
  input wire cmd_accept, // Carried out.
  input wire cmd_reject, // Refused.
  input wire lanes_quad // Four-lane mode.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Bounds assume the bench runs with a short write time of four clocks.
  sequence busy_hold;
    status_one[0] [*3];
  endsequence
  a_busy_len: assert property ($rose(status_one[0]) |-> busy_hold ##[1:4] !status_one[0])
    else $error("busy length wrong");
  a_latch_cause: assert property ($rose(status_one[1]) |-> $past(cmd_accept))
    else $error("latch set without accepted command");
  a_susp_cause: assert property ($rose(status_two[7]) |-> $past(cmd_accept))
    else $error("suspend set without accepted command");
  a_resv_zero: assert property (status_two[2] == 1'b0)
    else $error("reserved bit set");
  a_lock_sticky: assert property (1'b1 |=> (status_two[5:3] & $past(status_two[5:3])) == $past(status_two[5:3]))
    else $error("lock bit cleared");
  a_nolatch_ref: assert property (cmd_valid && cmd_op == `FSPR_OP_WRSR && !status_one[1] && !$past(cmd_accept)
    |=> !cmd_accept)
    else $error("write accepted without latch");
  a_cerase_ref: assert property (cmd_valid && cmd_op == `FSPR_OP_CERASE && status_one[4:2] != 3'h0
    && status_one[4:2] != 3'h7 |=> !cmd_accept)
    else $error("chip erase accepted");
  a_qread_ref: assert property (cmd_valid && cmd_op == `FSPR_OP_QREAD && !lanes_quad |=> !cmd_accept)
    else $error("quad read accepted");
  a_one_answer: assert property (cmd_accept |-> $past(cmd_valid) && !cmd_reject)
    else $error("answer without command");
endmodule // fspr_regs_monitor

/* File: dv/fspr_host.sv */
// ==========================================================================
// Host controller issuing decoded flash commands
module fspr_host (
  input wire clock, // System clock.
  input wire cmd_accept, // Carried out.
  input wire cmd_reject, // Refused.
  output logic cmd_valid, // Command strobe.
  output logic [3:0] cmd_op, // Operation.
  output logic [18:0] cmd_addr, // Target address.
  output logic [18:0] cmd_len, // Bytes minus one.
  output logic [7:0] cmd_s1, // Data for status_one.
  output logic [7:0] cmd_s2 // Data for status_two.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_valid, cmd_op, cmd_addr, cmd_len, cmd_s1, cmd_s2} = '0;
  end
  // One strobe per command; data lines are scrambled after release so stale values never look live.
  task send(input logic [3:0] op, input logic [7:0] s1, input logic [7:0] s2, input logic [18:0] addr,
    output int res);
    int i;
    @(posedge clock) #1;
    {cmd_valid, cmd_op, cmd_s1, cmd_s2, cmd_addr, cmd_len} = {1'b1, op, s1, s2, addr, 19'h0_00ff};
    @(posedge clock) #1;
    {cmd_valid, cmd_s1, cmd_s2, cmd_addr, cmd_len} = {1'b0, ~s1, ~s2, ~addr, 19'h7_ff00};
    res = 2;
    for (i = 0; i < 4 && res == 2; i++) begin
      if (cmd_accept === 1'b1) res = 1;
      else if (cmd_reject === 1'b1) res = 0;
      else @(posedge clock) #1;
    end
    repeat (2) @(posedge clock);
    #1;
  endtask
endmodule // fspr_host

/* File: dv/flash_status_protect_regs_tb.sv */
`include "fspr_defines.vh"
module flash_status_protect_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rstn = 0, guard_pin_n = 1, power_up_n = 1;
  logic cmd_valid, cmd_accept, cmd_reject, lanes_quad;
  logic [3:0] cmd_op;
  logic [18:0] cmd_addr, cmd_len;
  logic [7:0] cmd_s1, cmd_s2, status_one, status_two;
  int num_errors = 0, n_compared = 0, res, i;
  always #5 clock = ~clock;
  fspr_host host (.clock(clock), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_s1(cmd_s1), .cmd_s2(cmd_s2));
  // Clock gating stays idle; the write time is shortened to four clocks.
  fspr_regs #(.AW(19), .BUSY_CYCLES(4)) DUT (.clock(clock), .rstn(rstn), .clk_en(1'b1), .power_up_n(power_up_n),
    .guard_pin_n(guard_pin_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_s1(cmd_s1), .cmd_s2(cmd_s2), .cmd_sec_idx(2'h0), .status_one(status_one), .status_two(status_two),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .lanes_quad(lanes_quad));
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A host timeout shows as answer code 2 and ends the run.
  task cmd(input logic [3:0] op, input logic [7:0] s1, input logic [7:0] s2, input logic [18:0] a, input int e);
    host.send(op, s1, s2, a, res);
    chk(res[7:0], e[7:0]);
    if (res == 2) give_verdict;
  endtask
  task idle;
    for (i = 0; i < 20 && status_one[0] !== 1'b0; i++) @(posedge clock) #1;
    if (i == 20) begin
      num_errors++;
      give_verdict;
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock) #1;
    rstn = 1;
    chk(status_one, 8'h00);
    chk(status_two, 8'h00);
    cmd(`FSPR_OP_WRSR, 8'h04, 8'h0a, 0, 0);
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    chk(status_one, 8'h02);
    cmd(`FSPR_OP_WRSR, 8'h04, 8'h0a, 0, 1);
    chk(status_one[0], 1);
    idle();
    chk(status_one, 8'h04);
    chk(status_two, 8'h0a);
    chk(lanes_quad, 1);
    $display("test write status done");
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_PROG, 0, 0, 19'h7_0000, 0);
    cmd(`FSPR_OP_CERASE, 0, 0, 0, 0);
    cmd(`FSPR_OP_QREAD, 0, 0, 0, 1);
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_PROG, 0, 0, 19'h0_0000, 1);
    cmd(`FSPR_OP_SUSP, 0, 0, 0, 1);
    chk(status_two, 8'h8a);
    cmd(`FSPR_OP_RESUME, 0, 0, 0, 1);
    chk(status_two, 8'h0a);
    idle();
    $display("test protect and suspend done");
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_WRSR, 8'h80, 8'h00, 0, 1);
    idle();
    chk(status_two, 8'h08);
    chk(status_one, 8'h80);
    cmd(`FSPR_OP_QREAD, 0, 0, 0, 0);
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_SECW, 0, 0, 0, 0);
    cmd(`FSPR_OP_WRDI, 0, 0, 0, 1);
    chk(status_one, 8'h80);
    $display("test lock bits done");
    guard_pin_n = 0;
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_WRSR, 8'h7c, 8'h00, 0, 0);
    chk(status_one[6:2], 0);
    $display("test guard pin done");
    // Release the guard pin, then move to the power-cycle lock and clear it by a power pulse.
    guard_pin_n = 1;
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_WRSR, 8'h00, 8'h01, 0, 1);
    idle();
    chk(status_two, 8'h09);
    cmd(`FSPR_OP_WREN, 0, 0, 0, 1);
    cmd(`FSPR_OP_WRSR, 8'h00, 8'h00, 0, 0);
    power_up_n = 0;
    repeat (4) @(posedge clock) #1;
    power_up_n = 1;
    repeat (4) @(posedge clock) #1;
    chk(status_two, 8'h08);
    chk(status_one[7], 0);
    $display("test power lock done");
    give_verdict;
  end
endmodule // flash_status_protect_regs_tb
bind fspr_regs fspr_regs_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) mon (.clock(clock), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .status_one(status_one), .status_two(status_two),
  .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .lanes_quad(lanes_quad));
